// ### core/eep_pkg.sv
// shared constants and types for the serial eeprom slave
// Functional notes
// (RULE_01) select byte msb first: type, enables, direction
// (RULE_02) low select bits come from enable pins
// (RULE_03) enable pins compared live at each select
// (RULE_04) eight devices share one bus by enables
// (RULE_05) master opens each operation with start, select
// (RULE_06) device acks each written byte in ninth clock
// (RULE_07) master acks each read byte in ninth clock
// (RULE_08) current read: select with direction one
// (RULE_09) random read: address write, restart, read select
// (RULE_10) sequential read streams bytes, address auto increments
// (RULE_11) byte or sixteen byte page write, then programming
// (RULE_12) 2048 bytes, eleven bit byte address
// (RULE_13) master ends every transfer with stop
// (RULE_14) power-on reset blocks every operation
// (RULE_15) data line is open drain only
// (RULE_16) write control high protects, low unprotects
// (RULE_17) open write control reads as low
// (RULE_18) protected: ack select and address, not data
// (RULE_19) write control variant lacks multibyte mode
// (RULE_20) start and stop are data edges, clock high
// (RULE_21) stop after write programs, after read idles
// (RULE_22) data sampled on rising serial clock edge
// (RULE_23) watch for start, deaf while programming
// (RULE_24) page write wraps in low four bits
// (RULE_25) read pointer advances and rolls over
// (RULE_26) programming time is a parameter
package eep_pkg;
  localparam int unsigned ADDR_W = 11; // byte address width
  localparam int unsigned MEM_BYTES = 2048; // array size
  localparam int unsigned PAGE_W = 4; // page offset bits
  localparam int unsigned PAGE_BYTES = 16; // page size
  localparam int unsigned CE_W = 3; // chip enable pins
  localparam int unsigned HI_W = 3; // address bits in the high byte
  localparam int unsigned SEL_RW_BIT = 0; // direction bit of select
  localparam int unsigned SEL_CE_LSB = 1; // enable field low bit
  localparam int unsigned SEL_CODE_LSB = 4; // type code low bit
  localparam logic [3:0] TYPE_CODE_DEF = 4'h6; // arbitrary value
  localparam logic [3:0] BIT_ACK = 4'h8; // eight bits seen
  localparam logic [3:0] BIT_END = 4'h9; // ack clock seen
  localparam int unsigned CLK_MHZ = 40; // system clock rate
  localparam int unsigned PROG_TIME_US = 5000; // programming time
  localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ; // cycles
  localparam int unsigned FIFO_DEPTH = 2; // read data buffer entries
  // protocol phases of the slave
  typedef enum logic [2:0] {
    EEP_IDLE, EEP_DEVSEL, EEP_ADDR_HI, EEP_ADDR_LO,
    EEP_WDATA, EEP_RDATA, EEP_WAIT, EEP_PROG
  } eep_state_t;
endpackage

// ### core/eep_strm_if.sv
// valid/ready stream carrier between slave and buffer
`timescale 1ns/100ps
interface eep_strm_if #(parameter int unsigned W = 8);
  logic valid; // word offered
  logic ready; // word can be taken
  logic [W-1:0] data; // word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // eep_strm_if

// ### core/eep_mem.sv
// byte array with registered read data
`timescale 1ns/100ps
module eep_mem #(
  parameter int unsigned AW = 11,
  parameter int unsigned DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] arr [2**AW]; // storage cells
  // write port and registered read port
  always_ff @(posedge clk) begin
    if (we) begin
      arr[waddr] <= wdata;
    end
    if (re) begin
      rdata <= arr[raddr];
    end
  end
endmodule // eep_mem

// ### core/eep_buf.sv
// small ring buffer with valid/ready on both sides
`timescale 1ns/100ps
module eep_buf #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  eep_strm_if.snk in_s,
  eep_strm_if.src out_s
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // pointer bits
  localparam int unsigned CW = $clog2(DEPTH + 1); // count bits
  // depth must be a power of two for pointer wrap
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("eep_buf depth must be a power of two of at least two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] slot; // stored words
    logic [PW-1:0] wp; // write index
    logic [PW-1:0] rp; // read index
    logic [CW-1:0] cnt; // words held
  } eep_buf_st_t;
  eep_buf_st_t s_reg, s_next;
  logic push; // word enters
  logic pop; // word leaves
  // honest flags from the count
  assign in_s.ready = (s_reg.cnt != CW'(DEPTH));
  assign out_s.valid = (s_reg.cnt != '0);
  assign out_s.data = s_reg.slot[s_reg.rp];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  // next state; flush drops everything
  always_comb begin
    s_next = s_reg;
    if (flush) begin
      s_next.wp = '0;
      s_next.rp = '0;
      s_next.cnt = '0;
    end else begin
      if (push) begin
        s_next.slot[s_reg.wp] = in_s.data;
        s_next.wp = s_reg.wp + PW'(1);
      end
      if (pop) begin
        s_next.rp = s_reg.rp + PW'(1);
      end
      s_next.cnt = s_reg.cnt + CW'(push) - CW'(pop);
    end
  end
  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // eep_buf

// ### core/eep_slave.sv
// two-wire serial slave front end of the 2048 byte memory
`timescale 1ns/100ps
module eep_slave #(
  parameter logic [3:0] TYPE_CODE = eep_pkg::TYPE_CODE_DEF, // arbitrary value
  parameter int unsigned PROG_CYCLES = eep_pkg::PROG_CYCLES_DEF,
  parameter bit PAGE_MODE = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [eep_pkg::CE_W-1:0] chip_select_pins,
  input wire logic write_protect_n,
  output logic prog_busy
);
  localparam int unsigned AW = eep_pkg::ADDR_W; // address width
  localparam int unsigned PW = eep_pkg::PAGE_W; // page offset width
  localparam int unsigned NP = eep_pkg::PAGE_BYTES; // page bytes
  localparam int unsigned TW = $clog2(PROG_CYCLES + 1); // timer width
  localparam int unsigned FW = AW + 8; // buffer word: address and data
  // timer must cover the page commit walk
  if (PROG_CYCLES <= NP || 2**AW != eep_pkg::MEM_BYTES) begin : g_chk
    $error("eep_slave programming time too short or bad array size");
  end
  // whole slave state
  typedef struct packed {
    eep_pkg::eep_state_t st; // protocol phase
    logic scl_q; // clock level last cycle
    logic sda_q; // data level last cycle
    logic [3:0] bitcnt; // rising edges in this byte
    logic [7:0] sh; // received bits
    logic [7:0] tx; // bits still to send
    logic drive; // pulling data low
    logic sda_lvl; // open drain output level
    logic need_load; // next read byte wanted
    logic [AW-1:0] ptr; // internal byte address
    logic [AW-1:0] fetch_addr; // next address to prefetch
    logic [AW-1:0] fetch_tag; // address of read in flight
    logic fetch_pend; // read data awaiting the buffer
    logic [NP-1:0][7:0] page; // page latch
    logic [NP-1:0] pvalid; // latch entries written
    logic [4:0] wr_cnt; // data bytes taken
    logic [TW-1:0] timer; // programming cycle count
    logic busy; // programming under way
  } eep_st_t;
  eep_st_t s_reg, s_next;
  logic scl_rise; // serial clock rising
  logic scl_fall; // serial clock falling
  logic start_ev; // start seen
  logic stop_ev; // stop seen
  logic sel_match; // select byte addresses us
  logic protect; // writes blocked
  logic mem_we; // array write strobe
  logic [AW-1:0] mem_waddr; // array write address
  logic [7:0] mem_wdata; // array write data
  logic mem_re; // array read strobe
  logic [7:0] mem_rdata; // array read data
  logic buf_flush; // drop prefetched bytes
  logic [PW-1:0] cidx; // page slot under commit
  eep_strm_if #(.W(FW)) fill_if ();
  eep_strm_if #(.W(FW)) drain_if ();
  // bus condition detection on sampled levels
  assign scl_rise = scl_in && !s_reg.scl_q; // RULE_22
  assign scl_fall = !scl_in && s_reg.scl_q;
  assign start_ev = scl_in && s_reg.scl_q && s_reg.sda_q && !sda_in; // RULE_20
  assign stop_ev = scl_in && s_reg.scl_q && !s_reg.sda_q && sda_in; // RULE_20
  // select compare uses the live enable pins
  assign sel_match = (s_reg.sh[7:eep_pkg::SEL_CODE_LSB] == TYPE_CODE) // RULE_01
    && (s_reg.sh[eep_pkg::SEL_CODE_LSB-1:eep_pkg::SEL_CE_LSB] == chip_select_pins); // RULE_02 RULE_03 RULE_04
  // high protects; an open pin is pulled low off chip
  assign protect = write_protect_n; // RULE_16 RULE_17
  assign cidx = s_reg.timer[PW-1:0];
  // prefetched read words into the buffer
  assign fill_if.valid = s_reg.fetch_pend;
  assign fill_if.data = {s_reg.fetch_tag, mem_rdata};
  assign drain_if.ready = s_reg.need_load;
  // pins come straight from state flops
  assign sda_out = s_reg.sda_lvl; // RULE_15
  assign sda_oe = s_reg.drive;
  assign prog_busy = s_reg.busy;
  // next state of the slave
  always_comb begin
    s_next = s_reg;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    mem_re = 1'b0;
    buf_flush = 1'b0;
    s_next.scl_q = scl_in;
    s_next.sda_q = sda_in;
    // prefetch: buffer took the word
    if (s_reg.fetch_pend && fill_if.ready) begin
      s_next.fetch_pend = 1'b0;
    end
    // prefetch: issue next read while streaming
    if (s_reg.st == eep_pkg::EEP_RDATA && !s_reg.fetch_pend) begin
      mem_re = 1'b1;
      s_next.fetch_tag = s_reg.fetch_addr;
      s_next.fetch_addr = s_reg.fetch_addr + AW'(1); // RULE_25
      s_next.fetch_pend = 1'b1;
    end
    if (s_reg.st == eep_pkg::EEP_PROG) begin
      // programming: bus ignored, page committed
      s_next.timer = s_reg.timer + TW'(1); // RULE_23 RULE_26
      if (s_reg.timer < TW'(NP)) begin
        mem_we = s_reg.pvalid[cidx];
        mem_waddr = {s_reg.ptr[AW-1:PW], cidx};
        mem_wdata = s_reg.page[cidx];
      end
      if (s_reg.timer == TW'(PROG_CYCLES - 1)) begin
        s_next.st = eep_pkg::EEP_IDLE;
        s_next.busy = 1'b0;
        s_next.pvalid = '0;
      end
    end else if (start_ev) begin
      // start or restart: fresh select byte
      s_next.st = eep_pkg::EEP_DEVSEL; // RULE_05 RULE_23
      s_next.bitcnt = '0;
      s_next.drive = 1'b0;
      s_next.need_load = 1'b0;
      s_next.fetch_pend = 1'b0;
      s_next.pvalid = '0;
      s_next.wr_cnt = '0;
      buf_flush = 1'b1;
    end else if (stop_ev) begin
      // stop: program after write, else standby
      s_next.drive = 1'b0; // RULE_13
      s_next.need_load = 1'b0;
      s_next.fetch_pend = 1'b0;
      buf_flush = 1'b1;
      if (s_reg.st == eep_pkg::EEP_WDATA && s_reg.pvalid != '0) begin
        s_next.st = eep_pkg::EEP_PROG; // RULE_21 RULE_11
        s_next.timer = '0;
        s_next.busy = 1'b1;
      end else begin
        s_next.st = eep_pkg::EEP_IDLE; // RULE_21
      end
    end else if (s_reg.st != eep_pkg::EEP_IDLE) begin
      // sample on rising clock
      if (scl_rise) begin
        if (s_reg.bitcnt < eep_pkg::BIT_ACK) begin
          s_next.sh = {s_reg.sh[6:0], sda_in}; // RULE_22 RULE_01
        end else if (s_reg.st == eep_pkg::EEP_RDATA && sda_in) begin
          s_next.st = eep_pkg::EEP_WAIT; // RULE_07
        end
        s_next.bitcnt = s_reg.bitcnt + 4'h1;
      end
      // change data on falling clock
      if (scl_fall) begin
        if (s_reg.bitcnt == eep_pkg::BIT_ACK) begin
          // whole byte in: decide the ack
          s_next.drive = 1'b0;
          case (s_reg.st)
            eep_pkg::EEP_DEVSEL: begin
              if (sel_match) begin
                s_next.drive = 1'b1; // RULE_06 RULE_18
                if (s_reg.sh[eep_pkg::SEL_RW_BIT]) begin
                  s_next.st = eep_pkg::EEP_RDATA; // RULE_08 RULE_09
                  s_next.fetch_addr = s_reg.ptr;
                end else begin
                  s_next.st = eep_pkg::EEP_ADDR_HI;
                end
              end else begin
                s_next.st = eep_pkg::EEP_IDLE; // RULE_02
              end
            end
            eep_pkg::EEP_ADDR_HI: begin
              s_next.drive = 1'b1; // RULE_18
              s_next.ptr[AW-1:8] = s_reg.sh[eep_pkg::HI_W-1:0]; // RULE_12
              s_next.st = eep_pkg::EEP_ADDR_LO;
            end
            eep_pkg::EEP_ADDR_LO: begin
              s_next.drive = 1'b1; // RULE_18 RULE_09
              s_next.ptr[7:0] = s_reg.sh;
              s_next.st = eep_pkg::EEP_WDATA;
            end
            eep_pkg::EEP_WDATA: begin
              // protected, or beyond single byte without page mode: no ack
              if (!protect && (PAGE_MODE || s_reg.wr_cnt == '0)) begin // RULE_18 RULE_19
                s_next.drive = 1'b1; // RULE_06
                s_next.page[s_reg.ptr[PW-1:0]] = s_reg.sh; // RULE_11
                s_next.pvalid[s_reg.ptr[PW-1:0]] = 1'b1;
                s_next.ptr[PW-1:0] = s_reg.ptr[PW-1:0] + PW'(1); // RULE_24
                s_next.wr_cnt = s_reg.wr_cnt + 5'h01;
              end
            end
            default: begin
              s_next.drive = 1'b0; // release for master ack
            end
          endcase
        end else if (s_reg.bitcnt == eep_pkg::BIT_END) begin
          // ack clock over: release, next byte
          s_next.drive = 1'b0;
          s_next.bitcnt = '0;
          if (s_reg.st == eep_pkg::EEP_RDATA) begin
            s_next.need_load = 1'b1; // RULE_10
          end
        end else if (s_reg.st == eep_pkg::EEP_RDATA) begin
          // shift out next data bit
          s_next.drive = !s_reg.tx[7]; // RULE_15
          s_next.tx = {s_reg.tx[6:0], 1'b0};
        end
      end
      // read byte arrives from buffer
      if (s_reg.need_load && drain_if.valid) begin
        s_next.need_load = 1'b0;
        s_next.drive = !drain_if.data[7];
        s_next.tx = {drain_if.data[6:0], 1'b0};
        s_next.ptr = drain_if.data[FW-1:8] + AW'(1); // RULE_10 RULE_25
      end
    end
  end
  // state register; reset is power-on reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0; // RULE_14
      s_reg.scl_q <= 1'b1;
      s_reg.sda_q <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
  // prefetch buffer between array and shifter
  eep_buf #(.W(FW), .DEPTH(eep_pkg::FIFO_DEPTH)) u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(buf_flush),
    .in_s(fill_if.snk),
    .out_s(drain_if.src)
  );
  // storage array
  eep_mem #(.AW(AW), .DW(8)) u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .re(mem_re),
    .raddr(s_reg.fetch_addr),
    .rdata(mem_rdata)
  );
endmodule // eep_slave

// ### test/eep_master.sv
// two-wire bus master model: drives clock and pulls data low
`timescale 1ns/100ps
module eep_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  int lo_len = 5; // low phase stretch, raised for a slow master
  // bus idle high from time zero
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // waits n clocks, then steps just off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // start or restart: data falls while clock high
  task automatic start();
    pull = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(4);
    pull = 1'b1;
    hold(4);
    scl = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    hold(1);
    pull = 1'b1;
    hold(3);
    scl = 1'b1;
    hold(4);
    pull = 1'b0;
    hold(4);
  endtask
  // one bit: data moves only in the low phase
  task automatic bit_io(input logic b, output logic s);
    hold(1);
    pull = !b;
    hold(lo_len);
    scl = 1'b1;
    hold(3);
    s = sda;
    hold(1);
    scl = 1'b0;
  endtask
  // byte out msb first, ack read in ninth clock
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // byte in; low ninth bit asks for more
  task automatic get(output logic [7:0] d, input logic more);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!more, s);
  endtask
endmodule // eep_master

// ### test/eep_slave_sva.sv
// port checker for the serial eeprom slave
`timescale 1ns/100ps
module eep_slave_chk #(
  parameter logic [3:0] TYPE_CODE = 4'h6, // arbitrary value
  parameter int unsigned PROG_CYCLES = 200,
  parameter bit PAGE_MODE = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [eep_pkg::CE_W-1:0] chip_select_pins,
  input wire logic write_protect_n,
  input wire logic prog_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [31:0] busy_cnt_reg; // length of current busy run
  // counts consecutive busy cycles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) busy_cnt_reg <= 32'h0;
    else busy_cnt_reg <= prog_busy ? busy_cnt_reg + 32'h1 : 32'h0;
  end
  a_pin_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_oe_moves_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("data drive moved with clock high");
  a_oe_steady_high: assert property ($rose(scl_in) |-> $stable(sda_oe) [*3])
    else $error("data drive unstable in high phase");
  a_mute_while_busy: assert property (prog_busy |-> !sda_oe)
    else $error("answered while programming");
  a_prog_length: assert property ($fell(prog_busy) |-> busy_cnt_reg == PROG_CYCLES)
    else $error("programming length wrong");
  a_prog_on_stop: assert property ($rose(prog_busy) |-> $past(scl_in) && $past(sda_in) && !$past(sda_in, 2))
    else $error("programming began without stop");
  a_quiet_release: assert property ($fell(sys_rst) |-> !sda_oe && !prog_busy)
    else $error("active at reset release");
  a_free_after_stop: assert property (scl_in && $past(scl_in) && $rose(sda_in) |=> !sda_oe [*2])
    else $error("drove data after stop");
  c_prog: cover property ($rose(prog_busy));
  c_drive: cover property ($rose(sda_oe));
  c_stop: cover property (scl_in && $past(scl_in) && $rose(sda_in));
endmodule // eep_slave_chk
bind eep_slave eep_slave_chk #(.TYPE_CODE(TYPE_CODE), .PROG_CYCLES(PROG_CYCLES), .PAGE_MODE(PAGE_MODE)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .chip_select_pins(chip_select_pins), .write_protect_n(write_protect_n), .prog_busy(prog_busy));

// ### test/eep_slave_bench.sv
// self-checking bench for the serial eeprom slave
`timescale 1ns/100ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, a); end end
module eep_slave_bench;
  localparam logic [3:0] CODE = 4'h6; // arbitrary type code
  localparam logic [3:0] CODE2 = 4'hC; // arbitrary type code of the single byte variant
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl;
  logic pull;
  logic sda_out;
  logic sda_oe;
  logic prog_busy;
  logic sda_oe2; // data pull of the single byte variant
  logic busy2; // programming flag of the single byte variant
  logic [2:0] cs = 3'h5;
  logic wp = 1'b0; // low stands for an open pin
  wire logic sda = !(sda_oe | sda_oe2 | pull); // pulled-up wired line
  int err_count = 0;
  int total_checks = 0;
  logic ack;
  logic [7:0] rd;
  always #12.5 clk = !clk;
  eep_master m (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
  eep_slave #(.TYPE_CODE(CODE), .PROG_CYCLES(200)) dut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pins(cs), .write_protect_n(wp),
    .prog_busy(prog_busy));
  // second device on the same bus without multibyte mode
  eep_slave #(.TYPE_CODE(CODE2), .PROG_CYCLES(200), .PAGE_MODE(1'b0)) dut_single (.clk(clk), .sys_rst(sys_rst),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe2), .chip_select_pins(3'h0),
    .write_protect_n(wp), .prog_busy(busy2));
  // select byte: type, enables, direction
  function automatic logic [7:0] sel(input logic [2:0] e, input logic rw);
    return {CODE, e, rw};
  endfunction
  // select for write plus both address bytes
  task automatic addr(input logic [10:0] a);
    m.start();
    m.put(sel(cs, 1'b0), ack);
    `CHK("select ack", 1'b1, ack)
    m.put({5'h00, a[10:8]}, ack);
    `CHK("addr hi ack", 1'b1, ack)
    m.put(a[7:0], ack);
    `CHK("addr lo ack", 1'b1, ack)
  endtask
  // single byte current read, checked
  task automatic cur_read(input logic [7:0] exp);
    m.start();
    m.put(sel(cs, 1'b1), ack);
    `CHK("read select ack", 1'b1, ack)
    m.get(rd, 1'b0);
    `CHK("current byte", exp, rd)
    m.stop();
  endtask
  // bounded wait for programming to end
  task automatic wait_prog();
    int n;
    n = 0;
    while ((prog_busy | busy2) !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    #1;
    if (n >= 400) begin
      err_count++;
      give_verdict();
    end
  endtask
  // every enable setting answers its own bits, not those with bit 0 flipped
  task automatic t_select();
    for (int k = 0; k < 8; k++) begin
      cs = k[2:0];
      m.start();
      m.put(sel(k[2:0], 1'b0), ack);
      `CHK("own select", 1'b1, ack)
      m.start();
      m.put(sel(k[2:0] ^ 3'h1, 1'b0), ack);
      `CHK("other select", 1'b0, ack)
      m.stop();
    end
    m.start();
    m.put({~CODE, cs, 1'b0}, ack);
    `CHK("wrong type", 1'b0, ack)
    m.stop();
  endtask
  // three bytes wrap in page, busy after stop refuses bus
  task automatic t_page_write();
    addr(11'h3FE);
    for (int i = 0; i < 3; i++) begin
      m.put(8'hA0 + 8'(i), ack);
      `CHK("data ack", 1'b1, ack)
    end
    m.stop();
    `CHK("busy after stop", 1'b1, prog_busy)
    m.start();
    m.put(sel(cs, 1'b1), ack);
    `CHK("busy select ack", 1'b0, ack)
    m.stop();
    wait_prog();
  endtask
  // slow random read of two bytes, then wrapped slot
  task automatic t_reads();
    m.lo_len = 15;
    addr(11'h3FE);
    m.start();
    m.put(sel(cs, 1'b1), ack);
    `CHK("restart select ack", 1'b1, ack)
    m.get(rd, 1'b1);
    `CHK("random byte", 8'hA0, rd)
    `CHK("data pin level", 1'b0, sda_out)
    m.get(rd, 1'b0);
    `CHK("next byte", 8'hA1, rd)
    m.stop();
    m.lo_len = 5;
    addr(11'h3F0);
    m.stop();
    cur_read(8'hA2);
  endtask
  // protected data refused, contents kept
  task automatic t_protect();
    wp = 1'b1;
    addr(11'h3FE);
    m.put(8'h55, ack);
    `CHK("protected data ack", 1'b0, ack)
    m.stop();
    `CHK("protected busy", 1'b0, prog_busy)
    wp = 1'b0;
    addr(11'h3FE);
    m.stop();
    cur_read(8'hA0);
  endtask
  // single byte variant: second data byte refused, first kept
  task automatic t_single();
    m.start();
    m.put({CODE2, 4'h0}, ack);
    `CHK("single select ack", 1'b1, ack)
    m.put(8'h00, ack);
    m.put(8'h10, ack);
    m.put(8'h11, ack);
    `CHK("single first ack", 1'b1, ack)
    m.put(8'h22, ack);
    `CHK("single second ack", 1'b0, ack)
    m.stop();
    `CHK("single busy", 1'b1, busy2)
    wait_prog();
    m.start();
    m.put({CODE2, 4'h0}, ack);
    m.put(8'h00, ack);
    m.put(8'h10, ack);
    m.start();
    m.put({CODE2, 4'h1}, ack);
    `CHK("single read ack", 1'b1, ack)
    m.get(rd, 1'b0);
    `CHK("single byte", 8'h11, rd)
    m.stop();
  endtask
  // reset mid read silences the device, then it recovers
  task automatic t_reset();
    m.start();
    m.put(sel(cs, 1'b1), ack);
    m.hold(8);
    sys_rst = 1'b1;
    m.hold(1);
    `CHK("drive in reset", 1'b0, sda_oe)
    m.stop();
    m.start();
    m.put(sel(cs, 1'b0), ack);
    `CHK("ack in reset", 1'b0, ack)
    m.stop();
    sys_rst = 1'b0;
    m.hold(2);
    addr(11'h3FF);
    m.stop();
    cur_read(8'hA1);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    m.hold(2);
    t_select();
    cs = 3'h5;
    t_page_write();
    t_reads();
    t_protect();
    t_single();
    t_reset();
    give_verdict();
  end
  // prints the verdict and ends the run
  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
endmodule // eep_slave_bench
